// File: rtl/tlx_defs.vh
`ifndef TLX_DEFS_VH
`define TLX_DEFS_VH
// opcode patterns, matched against the upper bits of the instruction word
`define TLX_OPW_LATCH 6
`define TLX_OP_LATCH_READ 6'h28
`define TLX_OP_LATCH_WRITE 6'h29
`define TLX_OP_TABLE_WRITE 6'h2b
`define TLX_OP_TEST_SKIP 8'h33
`define TLX_OP_LIT_XOR 8'hb4
`define TLX_OPW_REG_XOR 7
`define TLX_OP_REG_XOR 7'h06
// instruction word field positions
`define TLX_BIT_T 9
`define TLX_BIT_D 8
`define TLX_BIT_I 8
// quarter phase codes
`define TLX_Q1 2'h0
`define TLX_Q2 2'h1
`define TLX_Q3 2'h2
`define TLX_Q4 2'h3
// reset values
`define TLX_RST_LATCH 16'h0000
`define TLX_RST_WORKING_REGISTER 8'h00
`endif

// File: rtl/tlx_phase.v
`timescale 1ns/1ps
`include "tlx_defs.vh"
module tlx_phase (
  input wire clk,
  input wire rst,
  output reg [1:0] phase,
  output wire cycle_start
);
  // four clocks form one instruction cycle, q1 to q4
  always @(posedge clk) begin
    if (rst) begin
      phase <= `TLX_Q1;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // pulse marks q4, the last quarter of the cycle
  assign cycle_start = (phase == `TLX_Q4);
endmodule

// File: rtl/tlx_exec.v
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "tlx_defs.vh"
// Functional notes
// - latch read copies chosen byte to f
// - latch read decoded from 1010 00tx
// - latch write loads f into byte
// - latch ops pair with table transfers
// - zero test discards prefetch, two cycles
// - test skip decoded by 0011 0011
// - literal xor into working register, zero
// - literal xor decoded by 1011 0100
// - register xor, d picks destination
// - table write sends full latch out
module tlx_exec (
  input wire clk,
  input wire rst,
  input wire [15:0] instr,
  input wire instr_valid,
  output reg [7:0] file_addr,
  output wire file_rd,
  input wire [7:0] file_rdata,
  output wire file_wr,
  output reg [7:0] file_wdata,
  output reg [7:0] working_register,
  output reg zero_flag,
  output reg [15:0] table_latch,
  output reg skip_next,
  output reg prog_wr,
  output reg [15:0] prog_wdata,
  output wire busy,
  output wire [1:0] phase
);
  wire cycle_end;
  reg [7:0] operand;
  reg [7:0] result;
  reg file_wr_q;
  reg skip_cycle;
  wire [7:0] xor_val;

  tlx_phase u_phase (
    .clk(clk),
    .rst(rst),
    .phase(phase),
    .cycle_start(cycle_end)
  );

  wire is_lrd = instr_valid && (instr[15:10] == `TLX_OP_LATCH_READ);
  wire is_lwt = instr_valid && (instr[15:10] == `TLX_OP_LATCH_WRITE);
  // table write decode, also loads the latch byte on the same q4 edge
  wire is_twt = instr_valid && (instr[15:10] == `TLX_OP_TABLE_WRITE);
  wire is_tst = instr_valid && (instr[15:8] == `TLX_OP_TEST_SKIP);
  wire is_lxr = instr_valid && (instr[15:8] == `TLX_OP_LIT_XOR);
  wire is_rxr = instr_valid && (instr[15:9] == `TLX_OP_REG_XOR);
  wire sel_high = instr[`TLX_BIT_T];
  wire dest_f = instr[`TLX_BIT_D];
  // the skipped slot is a forced no-operation, so nothing decodes in it
  wire live = !skip_cycle;

  assign file_rd = live && (phase == `TLX_Q2) && (is_lwt || is_twt || is_tst || is_rxr);
  assign file_wr = file_wr_q;
  assign busy = skip_cycle;
  assign xor_val = working_register ^ operand;

  // q2 operand capture, q3 processing
  always @(posedge clk) begin
    if (rst) begin
      operand <= 8'h00;
      result <= 8'h00;
      file_addr <= 8'h00;
    end else if (live) begin
      if (phase == `TLX_Q1) begin
        file_addr <= instr[7:0];
      end
      if (phase == `TLX_Q2) begin
        if (is_lxr) begin
          operand <= instr[7:0];
        end else if (is_lrd) begin
          operand <= sel_high ? table_latch[15:8] : table_latch[7:0];
        end else begin
          operand <= file_rdata;
        end
      end
      if (phase == `TLX_Q3) begin
        result <= (is_lxr || is_rxr) ? xor_val : operand;
      end
    end
  end

  // q4 writes to the destination; the pulse covers the q4 clock only
  always @(posedge clk) begin
    if (rst) begin
      file_wr_q <= 1'b0;
      file_wdata <= 8'h00;
      working_register <= `TLX_RST_WORKING_REGISTER;
      zero_flag <= 1'b0;
      table_latch <= `TLX_RST_LATCH;
    end else begin
      file_wr_q <= 1'b0;
      if (live && phase == `TLX_Q3) begin
        if (is_lrd || (is_rxr && dest_f)) begin
          file_wr_q <= 1'b1;
          file_wdata <= (is_rxr) ? xor_val : (sel_high ? table_latch[15:8] : table_latch[7:0]);
        end
      end
      if (live && phase == `TLX_Q4) begin
        if (is_lwt || is_twt) begin
          if (sel_high) begin
            table_latch[15:8] <= result;
          end else begin
            table_latch[7:0] <= result;
          end
        end
        // literal xor lands in working register
        if (is_lxr || (is_rxr && !dest_f)) begin
          working_register <= result;
        end
        if (is_lxr || is_rxr) begin
          zero_flag <= (result == 8'h00);
        end
      end
    end
  end

  // zero test kills the prefetched word
  always @(posedge clk) begin
    if (rst) begin
      skip_cycle <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      skip_next <= 1'b0;
      if (cycle_end) begin
        skip_cycle <= 1'b0;
        // test compares the captured operand; status flags stay untouched
        if (live && is_tst && operand == 8'h00) begin
          skip_cycle <= 1'b1;
          skip_next <= 1'b1;
        end
      end
    end
  end

  // table write ships the updated latch on the same q4 edge as the latch load
  // full sixteen bits to program memory
  always @(posedge clk) begin
    if (rst) begin
      prog_wr <= 1'b0;
      prog_wdata <= 16'h0000;
    end else begin
      prog_wr <= 1'b0;
      if (live && phase == `TLX_Q4 && is_twt) begin
        prog_wr <= 1'b1;
        prog_wdata <= sel_high ? {result, table_latch[7:0]} : {table_latch[15:8], result};
      end
    end
  end
endmodule

// File: tb/tlx_props.sv
`timescale 1ns/1ps
module tlx_props (
  input wire clk,
  input wire rst,
  input wire [15:0] instr,
  input wire instr_valid,
  input wire file_rd,
  input wire [7:0] file_rdata,
  input wire file_wr,
  input wire [7:0] file_wdata,
  input wire [7:0] working_register,
  input wire zero_flag,
  input wire [15:0] table_latch,
  input wire skip_next,
  input wire busy,
  input wire [1:0] phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // last quarter of an accepted instruction
  wire q4 = phase == 2'h3 && instr_valid && !busy;
  a_phase_step: assert property (1'b1 |=> phase == $past(phase) + 2'h1) else $error("phase");
  a_read_q2: assert property (file_rd |-> phase == 2'h1) else $error("file_rd");
  a_write_q4: assert property (file_wr |-> phase == 2'h3 && (instr[15:10] == 6'h28 || instr[15:9] == 7'h06)) else $error("file_wr");
  a_latch_read: assert property (file_wr && instr[15:10] == 6'h28
    |-> file_wdata == (instr[9] ? table_latch[15:8] : table_latch[7:0])) else $error("latch read");
  a_skip_zero: assert property (q4 && instr[15:8] == 8'h33
    |=> skip_next == ($past(file_rdata, 3) == 8'h00) && $stable(zero_flag)) else $error("skip");
  a_skip_busy: assert property (skip_next |-> busy [*4] ##1 !busy) else $error("busy");
  a_lit_xor: assert property (q4 && instr[15:8] == 8'hb4 |=> working_register == ($past(working_register)
    ^ $past(instr[7:0])) && zero_flag == (working_register == 8'h00)) else $error("lit xor");
  a_reg_xor: assert property (file_wr && instr[15:9] == 7'h06
    |-> file_wdata == (working_register ^ $past(file_rdata, 2))) else $error("reg xor");
  c_skip: cover property (skip_next);
  c_write: cover property (file_wr);
  c_lit: cover property (q4 && instr[15:8] == 8'hb4);
endmodule
bind tlx_exec tlx_props u_props (.*);

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] instr = 16'h0000;
  reg instr_valid = 1'b0;
  reg [7:0] file_rdata = 8'h00;
  wire file_rd, file_wr, zero_flag, skip_next, prog_wr, busy;
  wire [7:0] file_addr, file_wdata, working_register;
  wire [15:0] table_latch, prog_wdata;
  wire [1:0] phase;
  reg [7:0] wd;
  reg wr;
  integer miscompares = 0;
  integer compares = 0;
  tlx_exec u_dut (.*);
  // free running clock
  initial forever #20 clk = ~clk;
  task chk(input [31:0] n, input [15:0] e, input [15:0] g);
    compares = compares + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("BAD %0s exp %h got %h", n, e, g);
    end
  endtask
  // an idle cycle then one instruction; operand line inverted once released
  task op(input [15:0] i, input [7:0] d);
    // look at phase only once it has settled, then start at the q4 edge
    #1;
    while (phase !== 2'h3) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    instr <= i;
    file_rdata <= d;
    instr_valid <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    wr = file_wr;
    wd = file_wdata;
    @(posedge clk);
    instr_valid <= 1'b0;
    file_rdata <= ~d;
    #1;
  endtask
  task t_latch;
    op(16'ha510, 8'hb7);
    chk("ltch", 16'h00b7, table_latch);
    op(16'ha610, 8'h53);
    chk("ltch", 16'h53b7, table_latch);
    op(16'ha110, 8'h00);
    chk("rdlo", 16'h01b7, {7'h00, wr, wd});
    op(16'ha210, 8'h00);
    chk("rdhi", 16'h0153, {7'h00, wr, wd});
    chk("ltch", 16'h53b7, table_latch);
    op(16'hae10, 8'haa);
    chk("prog", 16'haab7, prog_wdata);
    chk("pwr", 16'h0001, {15'h0000, prog_wr});
  endtask
  task t_xor;
    op(16'hb4b5, 8'h00);
    chk("wz", 16'h00b5, {7'h00, zero_flag, working_register});
    op(16'h0d20, 8'haf);
    chk("xorf", 16'h011a, {7'h00, wr, wd});
    chk("wz", 16'h00b5, {7'h00, zero_flag, working_register});
    op(16'h0c20, 8'hb5);
    chk("wz", 16'h0100, {7'h00, zero_flag, working_register});
  endtask
  task t_skip;
    op(16'h3340, 8'h00);
    chk("skip", 16'h0003, {14'h0000, skip_next, busy});
    op(16'h3340, 8'h05);
    chk("skip", 16'h0000, {14'h0000, skip_next, busy});
    chk("zf", 16'h0001, {15'h0000, zero_flag});
    op(16'h3340, 8'h00);
    // a word offered inside the discarded slot must be ignored
    @(posedge clk);
    instr <= 16'hb4ff;
    instr_valid <= 1'b1;
    repeat (4) @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("nop", 16'h0100, {7'h00, zero_flag, working_register});
  endtask
  // reset in mid-run clears the state, and work resumes afterwards
  task t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rstl", 16'h0000, table_latch);
    chk("rstw", 16'h0000, {7'h00, zero_flag, working_register});
    op(16'hb4b5, 8'h00);
    chk("wz", 16'h00b5, {7'h00, zero_flag, working_register});
  endtask
  task stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_latch;
    t_xor;
    t_skip;
    t_reset;
    stop_test;
  end
  // hang guard, far beyond the roughly 114 clock cycles needed
  initial begin
    #100000;
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule
